// ===== pkg/cscr_pkg.sv
`default_nettype none
package cscr_pkg;
  // Register byte addresses; the word is decoded on haddr[7:2]
  localparam logic [31:0] OFF_LOW_POWER = 32'h0000_0010;
  localparam logic [31:0] OFF_CORE_CFG  = 32'h0000_0014;
  localparam logic [31:0] OFF_FAULT_PRI = 32'h0000_0018;
  localparam logic [31:0] OFF_SVC_PRI   = 32'h0000_001C;
  localparam logic [31:0] OFF_TIMER_PRI = 32'hE000_ED20;
  localparam int          NUM_REGS      = 5;
  localparam logic [2:0]  IDX_LOW_POWER = 3'h0;
  localparam logic [2:0]  IDX_CORE_CFG  = 3'h1;
  localparam logic [2:0]  IDX_FAULT_PRI = 3'h2;
  localparam logic [2:0]  IDX_SVC_PRI   = 3'h3;
  localparam logic [2:0]  IDX_TIMER_PRI = 3'h4;
  // Control bit positions
  localparam int LP_WAKE_ANY_BIT   = 4;
  localparam int LP_DEEP_BIT       = 2;
  localparam int LP_SOE_BIT        = 1;
  localparam int CC_ALIGN8_BIT     = 9;
  localparam int CC_BF_IGNORE_BIT  = 8;
  localparam int CC_DIV0_BIT       = 4;
  localparam int CC_UNALIGN_BIT    = 3;
  localparam int CC_UTRIG_BIT      = 1;
  localparam int CC_THREAD_ANY_BIT = 0;
  // Priority field positions
  localparam int PRI_MMF_POS  = 0;
  localparam int PRI_BF_POS   = 8;
  localparam int PRI_UF_POS   = 16;
  localparam int PRI_SVC_POS  = 24;
  localparam int PRI_PSV_POS  = 16;
  localparam int PRI_TICK_POS = 24;
  // Implemented bits of each register
  localparam logic [31:0] MASK_LOW_POWER = 32'h0000_0016;
  localparam logic [31:0] MASK_CORE_CFG  = 32'h0000_031B;
  localparam logic [31:0] MASK_FAULT_PRI = 32'h00F0_F0F0;
  localparam logic [31:0] MASK_SVC_PRI   = 32'hF000_0000;
  localparam logic [31:0] MASK_TIMER_PRI = 32'hF0F0_0000;
  // Reset values
  localparam logic [31:0] RST_LOW_POWER = 32'h0000_0000;
  localparam logic [31:0] RST_CORE_CFG  = 32'h0000_0200;
  localparam logic [31:0] RST_PRI       = 32'h0000_0000;
  // AHB encodings
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_SLEEP} cscr_pwr_type;

  typedef struct packed {
    logic wait_for_event_instruction; // Wait-for-event executes
    logic send_event_instruction;     // Send-event executes
    logic irq_pend_en;     // Enabled interrupt becomes pending
    logic irq_pend_dis;    // Disabled interrupt becomes pending
    logic event_en;        // Enabled event becomes pending
    logic handler_return;  // Return from Handler to Thread mode
    logic exc_entry;       // Exception entry stacking
    logic entry_sp_bit2;   // Bit 2 of stack pointer at entry
    logic exception_return; // Exception return unstacking
    logic stacked_align;   // Bit 9 of stacked status word
    logic dbus_fault;      // Data bus fault from load or store
    logic top_priority;    // Running at priority -1 or -2
    logic div_zero;        // Divide with zero divisor
    logic unal_access;     // Unaligned halfword or word access
    logic unal_multi;      // Unaligned multiple or doubleword
    logic trig_access;     // Access to the trigger register
    logic trig_privileged; // That access is privileged
    logic thread_return;   // Return value asks for Thread mode
    logic other_active;    // Other exceptions still active
  } cscr_core_in_type;

  typedef struct packed {
    logic sleeping;
    logic deep_sleep;
    logic wake;
    logic entry_pad4;
    logic stacked_align_bit;
    logic return_pad_remove;
    logic bus_fault_raise;
    logic bus_fault_ignored;
    logic lockup;
    logic div_fault;
    logic div_quot_zero;
    logic usage_unaligned;
    logic trig_grant;
    logic trig_deny;
    logic thread_ok;
    logic thread_fault;
  } cscr_core_out_type;

  typedef struct packed {
    logic [7:0] memmanage_fault_priority;
    logic [7:0] bus_fault_priority;
    logic [7:0] usage_fault_priority;
    logic [7:0] supervisor_call_priority;
    logic [7:0] pendable_service_priority;
    logic [7:0] tick_timer_priority;
  } cscr_prio_type;
endpackage
`default_nettype wire

// ===== logic/cscr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module cscr_regs (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [3:0]                 hprot,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  input  wire logic                       ext_event,
  input  wire cscr_pkg::cscr_core_in_type core_in,
  output cscr_pkg::cscr_core_out_type     core_out,
  output cscr_pkg::cscr_prio_type         prio
);

  typedef struct packed {
    cscr_pkg::cscr_pwr_type       pwr;
    logic                         ev_latch;
    logic [1:0]                   ext_sync;
    logic [4:0][31:0]             regs;
    logic                         dp_wr;
    logic [2:0]                   dp_idx;
    logic [3:0]                   dp_be;
    logic [31:0]                  rdata;
    cscr_pkg::cscr_core_out_type  out;
  } cscr_state_type;

  localparam logic [4:0][31:0] REG_MASK = {
    cscr_pkg::MASK_TIMER_PRI, cscr_pkg::MASK_SVC_PRI,
    cscr_pkg::MASK_FAULT_PRI, cscr_pkg::MASK_CORE_CFG,
    cscr_pkg::MASK_LOW_POWER};

  localparam logic [4:0][31:0] REG_RST = {
    cscr_pkg::RST_PRI, cscr_pkg::RST_PRI, cscr_pkg::RST_PRI,
    cscr_pkg::RST_CORE_CFG, cscr_pkg::RST_LOW_POWER};

  cscr_state_type st_r;
  cscr_state_type st_nxt;

  logic        addr_take;
  logic        addr_hit;
  logic [2:0]  addr_idx;
  logic [3:0]  addr_be;
  logic        ev_any;
  logic        irq_wake;
  logic [31:0] lp;
  logic [31:0] cc;
  logic [31:0] be_bits;

  assign lp = st_r.regs[cscr_pkg::IDX_LOW_POWER];
  assign cc = st_r.regs[cscr_pkg::IDX_CORE_CFG];

  ////////////////////////////////////////////////////////////////////////
  // Address phase decode

  assign addr_take = hsel && hready && htrans[1];

  always_comb begin
    addr_hit = 1'b1;
    addr_idx = cscr_pkg::IDX_LOW_POWER;
    if (haddr[7:2] == cscr_pkg::OFF_LOW_POWER[7:2]) begin
      addr_idx = cscr_pkg::IDX_LOW_POWER;
    end else if (haddr[7:2] == cscr_pkg::OFF_CORE_CFG[7:2]) begin
      addr_idx = cscr_pkg::IDX_CORE_CFG;
    end else if (haddr[7:2] == cscr_pkg::OFF_FAULT_PRI[7:2]) begin
      addr_idx = cscr_pkg::IDX_FAULT_PRI;
    end else if (haddr[7:2] == cscr_pkg::OFF_SVC_PRI[7:2]) begin
      addr_idx = cscr_pkg::IDX_SVC_PRI;
    end else if (haddr[7:2] == cscr_pkg::OFF_TIMER_PRI[7:2]) begin
      addr_idx = cscr_pkg::IDX_TIMER_PRI;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Byte lanes; control registers take whole words only
  always_comb begin
    addr_be = 4'h0;
    if (hsize == cscr_pkg::HSIZE_WORD) begin
      addr_be = 4'hF;
    end else if (addr_idx >= cscr_pkg::IDX_FAULT_PRI) begin
      if (hsize == cscr_pkg::HSIZE_BYTE) begin
        addr_be = 4'(4'h1 << haddr[1:0]);
      end else if (hsize == cscr_pkg::HSIZE_HALF) begin
        addr_be = 4'(4'h3 << {haddr[1], 1'b0});
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_bits[i*8 +: 8] = {8{st_r.dp_be[i]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake sources

  assign irq_wake = core_in.irq_pend_en
                 || (lp[cscr_pkg::LP_WAKE_ANY_BIT]
                     && core_in.irq_pend_dis);
  assign ev_any = irq_wake || core_in.event_en
               || core_in.send_event_instruction || st_r.ext_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_event};
    st_nxt.dp_wr = 1'b0;
    st_nxt.out.wake = 1'b0;

    // Bus write lands in the data phase
    if (st_r.dp_wr) begin
      st_nxt.regs[st_r.dp_idx] =
        (st_r.regs[st_r.dp_idx] & ~(be_bits & REG_MASK[st_r.dp_idx]))
        | (hwdata & be_bits & REG_MASK[st_r.dp_idx]);
    end

    // Privileged, mapped accesses only; others read zero
    if (addr_take) begin
      st_nxt.rdata = 32'h0000_0000;
      if (addr_hit && hprot[1]) begin
        st_nxt.dp_wr  = hwrite && (addr_be != 4'h0);
        st_nxt.dp_idx = addr_idx;
        st_nxt.dp_be  = addr_be;
        if (!hwrite) begin
          st_nxt.rdata = st_r.regs[addr_idx];
        end
      end
    end

    // Low-power sequencing
    case (st_r.pwr)
      cscr_pkg::PWR_RUN: begin
        if (core_in.wait_for_event_instruction) begin
          if (st_r.ev_latch || ev_any) begin
            st_nxt.ev_latch = 1'b0;
            st_nxt.out.wake = 1'b1;
          end else begin
            st_nxt.pwr = cscr_pkg::PWR_WAIT;
          end
        end else if (core_in.handler_return
                     && lp[cscr_pkg::LP_SOE_BIT]) begin
          st_nxt.pwr = cscr_pkg::PWR_SLEEP;
          st_nxt.ev_latch = st_r.ev_latch || ev_any;
        end else if (ev_any) begin
          st_nxt.ev_latch = 1'b1;
        end
      end
      cscr_pkg::PWR_WAIT: begin
        if (ev_any) begin
          st_nxt.pwr = cscr_pkg::PWR_RUN;
          st_nxt.out.wake = 1'b1;
        end
      end
      cscr_pkg::PWR_SLEEP: begin
        if (irq_wake) begin
          st_nxt.pwr = cscr_pkg::PWR_RUN;
          st_nxt.out.wake = 1'b1;
        end else if (ev_any) begin
          st_nxt.ev_latch = 1'b1;
        end
      end
      default: begin
        st_nxt.pwr = cscr_pkg::PWR_RUN;
      end
    endcase
    st_nxt.out.sleeping = (st_nxt.pwr != cscr_pkg::PWR_RUN);
    st_nxt.out.deep_sleep = st_nxt.out.sleeping
                         && lp[cscr_pkg::LP_DEEP_BIT];

    // Stack alignment on entry and return
    st_nxt.out.entry_pad4 = core_in.exc_entry
                         && cc[cscr_pkg::CC_ALIGN8_BIT]
                         && core_in.entry_sp_bit2;
    st_nxt.out.stacked_align_bit = st_nxt.out.entry_pad4;
    st_nxt.out.return_pad_remove = core_in.exception_return
                                && core_in.stacked_align;

    // Data bus faults
    st_nxt.out.bus_fault_raise = core_in.dbus_fault
                              && !core_in.top_priority;
    st_nxt.out.bus_fault_ignored = core_in.dbus_fault
                                && core_in.top_priority
                                && cc[cscr_pkg::CC_BF_IGNORE_BIT];
    if (core_in.dbus_fault && core_in.top_priority
        && !cc[cscr_pkg::CC_BF_IGNORE_BIT]) begin
      st_nxt.out.lockup = 1'b1;
    end

    // Divide by zero
    st_nxt.out.div_fault = core_in.div_zero
                        && cc[cscr_pkg::CC_DIV0_BIT];
    st_nxt.out.div_quot_zero = core_in.div_zero
                            && !cc[cscr_pkg::CC_DIV0_BIT];

    // Unaligned accesses
    st_nxt.out.usage_unaligned = core_in.unal_multi
      || (core_in.unal_access && cc[cscr_pkg::CC_UNALIGN_BIT]);

    // Software trigger access gate
    st_nxt.out.trig_grant = core_in.trig_access
      && (core_in.trig_privileged
          || cc[cscr_pkg::CC_UTRIG_BIT]);
    st_nxt.out.trig_deny = core_in.trig_access
                        && !st_nxt.out.trig_grant;

    // Thread mode entry policy
    st_nxt.out.thread_ok = core_in.thread_return
      && (!core_in.other_active
          || cc[cscr_pkg::CC_THREAD_ANY_BIT]);
    st_nxt.out.thread_fault = core_in.thread_return
                           && !st_nxt.out.thread_ok;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.pwr <= cscr_pkg::PWR_RUN;
      st_r.regs <= REG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.rdata;
  assign core_out  = st_r.out;

  always_comb begin
    prio.memmanage_fault_priority =
      st_r.regs[cscr_pkg::IDX_FAULT_PRI][cscr_pkg::PRI_MMF_POS +: 8];
    prio.bus_fault_priority =
      st_r.regs[cscr_pkg::IDX_FAULT_PRI][cscr_pkg::PRI_BF_POS +: 8];
    prio.usage_fault_priority =
      st_r.regs[cscr_pkg::IDX_FAULT_PRI][cscr_pkg::PRI_UF_POS +: 8];
    prio.supervisor_call_priority =
      st_r.regs[cscr_pkg::IDX_SVC_PRI][cscr_pkg::PRI_SVC_POS +: 8];
    prio.pendable_service_priority =
      st_r.regs[cscr_pkg::IDX_TIMER_PRI][cscr_pkg::PRI_PSV_POS +: 8];
    prio.tick_timer_priority =
      st_r.regs[cscr_pkg::IDX_TIMER_PRI][cscr_pkg::PRI_TICK_POS +: 8];
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wait_entered;
    core_in.wait_for_event_instruction && !ev_any && !st_r.ev_latch
      && st_r.pwr == cscr_pkg::PWR_RUN;
  endsequence

  sequence s_event_arrives;
    ev_any && st_r.pwr == cscr_pkg::PWR_WAIT;
  endsequence

  a_any_pending_wake: assert property (
    st_r.pwr != cscr_pkg::PWR_RUN && core_in.irq_pend_dis
      && lp[cscr_pkg::LP_WAKE_ANY_BIT]
    |=> core_out.wake && !core_out.sleeping)
    else $error("disabled interrupt did not wake with wake-any set");

  a_wait_event_wake: assert property (
    s_wait_entered ##1 s_event_arrives
    |=> core_out.wake && !core_out.sleeping)
    else $error("event did not end the wait");

  a_latched_event: assert property (
    st_r.pwr == cscr_pkg::PWR_RUN && st_r.ev_latch
      && core_in.wait_for_event_instruction
    |=> core_out.wake && !core_out.sleeping && !st_r.ev_latch)
    else $error("latched event did not satisfy the next wait");

  a_ext_event_wake: assert property (
    $rose(ext_event) ##1 1'b1 ##0
      st_r.pwr == cscr_pkg::PWR_WAIT [*2]
    |=> core_out.wake)
    else $error("external event did not wake the core");

  a_deep_select: assert property (
    core_out.sleeping |-> core_out.deep_sleep
      == $past(lp[cscr_pkg::LP_DEEP_BIT]))
    else $error("deep sleep output disagrees with select bit");

  a_sleep_on_exit: assert property (
    st_r.pwr == cscr_pkg::PWR_RUN && core_in.handler_return
      && !core_in.wait_for_event_instruction && !lp[cscr_pkg::LP_SOE_BIT]
    |=> !core_out.sleeping)
    else $error("slept on return with sleep-on-exit clear");

  a_bus_fault_lock: assert property (
    core_in.dbus_fault && core_in.top_priority
      && !cc[cscr_pkg::CC_BF_IGNORE_BIT]
    |=> core_out.lockup [*3])
    else $error("top-priority bus fault did not lock up");

  a_div_zero: assert property (
    core_in.div_zero |=> core_out.div_fault
      == $past(cc[cscr_pkg::CC_DIV0_BIT])
      && core_out.div_quot_zero != core_out.div_fault)
    else $error("divide by zero outcome wrong");

  a_unaligned_multi: assert property (
    core_in.unal_multi |=> core_out.usage_unaligned)
    else $error("unaligned multiple access did not fault");

  a_busfault_ignore: assert property (
    core_in.dbus_fault && core_in.top_priority
      && cc[cscr_pkg::CC_BF_IGNORE_BIT]
    |=> core_out.bus_fault_ignored && !core_out.bus_fault_raise)
    else $error("top-priority bus fault was not ignored");

  a_unaligned_trap: assert property (
    core_in.unal_access && !core_in.unal_multi
    |=> core_out.usage_unaligned == $past(cc[cscr_pkg::CC_UNALIGN_BIT]))
    else $error("unaligned access trap disagrees with trap bit");

  a_trigger_gate: assert property (
    core_in.trig_access && !core_in.trig_privileged
    |=> core_out.trig_grant == $past(cc[cscr_pkg::CC_UTRIG_BIT]))
    else $error("unprivileged trigger access gate wrong");

  a_thread_policy: assert property (
    core_in.thread_return && core_in.other_active
    |=> core_out.thread_ok == $past(cc[cscr_pkg::CC_THREAD_ANY_BIT]))
    else $error("thread entry policy wrong");

  a_priv_only: assert property (
    addr_take && !hprot[1] && !hwrite |=> hrdata == 32'h0000_0000)
    else $error("unprivileged read returned data");

  a_pri_low_zero: assert property (
    (prio.bus_fault_priority[3:0] == 4'h0)
      && (prio.tick_timer_priority[3:0] == 4'h0)
      && (st_r.regs[cscr_pkg::IDX_SVC_PRI][23:0] == 24'h0))
    else $error("unimplemented priority bits are not zero");

endmodule
`default_nettype wire

// ===== verification/core_system_control_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module core_system_control_regs_tb;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } cscr_reg_row_type;
  typedef struct packed {
    logic [31:0]                 cfg;
    cscr_pkg::cscr_core_in_type  ci;
    cscr_pkg::cscr_core_out_type co;
  } cscr_core_row_type;

  logic                        hclk = 1'b0;
  logic                        hresetn;
  logic                        hsel;
  logic [31:0]                 haddr;
  logic [1:0]                  htrans;
  logic                        hwrite;
  logic [2:0]                  hsize;
  logic [3:0]                  hprot;
  logic [31:0]                 hwdata;
  logic                        hreadyout;
  logic                        hresp;
  logic [31:0]                 hrdata;
  logic                        ext_event;
  cscr_pkg::cscr_core_in_type  core_in;
  cscr_pkg::cscr_core_out_type core_out;
  cscr_pkg::cscr_prio_type     prio;
  int                          failures;
  int                          num_checks;
  logic [31:0]                 d;
  logic                        found;
  cscr_reg_row_type            rrow [6];
  cscr_core_row_type           crow [14];

  cscr_regs cscr_regs_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hprot     (hprot),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .ext_event (ext_event),
    .core_in   (core_in),
    .core_out  (core_out),
    .prio      (prio)
  );

  always #4 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for the slave to accept the current phase
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        failures++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] addr,
                     input logic [2:0] size, input logic priv,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= addr;
    hwrite <= wr;
    hsize  <= size;
    hprot  <= {2'h0, priv, 1'b1};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, addr, cscr_pkg::HSIZE_WORD, 1'b1, wd, x);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, addr, cscr_pkg::HSIZE_WORD, 1'b1, 32'h0, x);
    check({16'h0, x}, {16'h0, exp});
  endtask

  // One-cycle core pulse; core_out is looked at just after its edge
  task automatic pulse(input cscr_pkg::cscr_core_in_type v);
    @(posedge hclk);
    core_in <= v;
    @(posedge hclk);
    core_in <= '0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = cscr_pkg::HSIZE_WORD;
    hprot = 4'h3;
    hwdata = 32'h0;
    ext_event = 1'b0;
    core_in = '0;
    failures = 0;
    num_checks = 0;
    rrow[0] = '{cscr_pkg::OFF_LOW_POWER, 32'hFFFF_FFFF, 32'h0000_0016};
    rrow[1] = '{cscr_pkg::OFF_CORE_CFG, 32'hFFFF_FFFF, 32'h0000_031B};
    rrow[2] = '{cscr_pkg::OFF_FAULT_PRI, 32'hFFFF_FFFF, 32'h00F0_F0F0};
    rrow[3] = '{cscr_pkg::OFF_SVC_PRI, 32'hFFFF_FFFF, 32'hF000_0000};
    rrow[4] = '{cscr_pkg::OFF_TIMER_PRI, 32'hFFFF_FFFF, 32'hF0F0_0000};
    rrow[5] = '{32'h0000_0024, 32'hFFFF_FFFF, 32'h0000_0000};
    crow[0] = '{32'h200, '{exc_entry:1'b1, entry_sp_bit2:1'b1, default:1'b0},
      '{entry_pad4:1'b1, stacked_align_bit:1'b1, default:1'b0}};
    crow[1] = '{32'h000, '{exc_entry:1'b1, entry_sp_bit2:1'b1, default:1'b0},
      '{default:1'b0}};
    crow[2] = '{32'h000, '{exception_return:1'b1, stacked_align:1'b1,
      default:1'b0}, '{return_pad_remove:1'b1, default:1'b0}};
    crow[3] = '{32'h010, '{div_zero:1'b1, default:1'b0},
      '{div_fault:1'b1, default:1'b0}};
    crow[4] = '{32'h000, '{div_zero:1'b1, default:1'b0},
      '{div_quot_zero:1'b1, default:1'b0}};
    crow[5] = '{32'h008, '{unal_access:1'b1, default:1'b0},
      '{usage_unaligned:1'b1, default:1'b0}};
    crow[6] = '{32'h000, '{unal_access:1'b1, default:1'b0},
      '{default:1'b0}};
    crow[7] = '{32'h000, '{unal_multi:1'b1, default:1'b0},
      '{usage_unaligned:1'b1, default:1'b0}};
    crow[8] = '{32'h002, '{trig_access:1'b1, default:1'b0},
      '{trig_grant:1'b1, default:1'b0}};
    crow[9] = '{32'h000, '{trig_access:1'b1, default:1'b0},
      '{trig_deny:1'b1, default:1'b0}};
    crow[10] = '{32'h000, '{thread_return:1'b1, other_active:1'b1,
      default:1'b0}, '{thread_fault:1'b1, default:1'b0}};
    crow[11] = '{32'h001, '{thread_return:1'b1, other_active:1'b1,
      default:1'b0}, '{thread_ok:1'b1, default:1'b0}};
    crow[12] = '{32'h100, '{dbus_fault:1'b1, top_priority:1'b1,
      default:1'b0}, '{bus_fault_ignored:1'b1, default:1'b0}};
    crow[13] = '{32'h000, '{dbus_fault:1'b1, default:1'b0},
      '{bus_fault_raise:1'b1, default:1'b0}};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rrow[i]) begin
      wr(rrow[i].addr, rrow[i].wdata);
      rd_chk(rrow[i].addr, rrow[i].exp);
    end
    foreach (crow[i]) begin
      wr(cscr_pkg::OFF_CORE_CFG, crow[i].cfg);
      pulse(crow[i].ci);
      check({32'h0, core_out}, {32'h0, crow[i].co});
    end
    // Second reset in mid-run brings back the reset values
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(cscr_pkg::OFF_LOW_POWER, 32'h0000_0000);
    rd_chk(cscr_pkg::OFF_CORE_CFG, 32'h0000_0200);
    rd_chk(cscr_pkg::OFF_FAULT_PRI, 32'h0000_0000);
    rd_chk(cscr_pkg::OFF_SVC_PRI, 32'h0000_0000);
    rd_chk(cscr_pkg::OFF_TIMER_PRI, 32'h0000_0000);
    // Unprivileged accesses: write dropped, read gives zero
    bus(1'b1, cscr_pkg::OFF_LOW_POWER, cscr_pkg::HSIZE_WORD, 1'b0,
        32'hFFFF_FFFF, d);
    bus(1'b0, cscr_pkg::OFF_CORE_CFG, cscr_pkg::HSIZE_WORD, 1'b0, 32'h0, d);
    check({16'h0, d}, 48'h0);
    check({47'h0, hresp}, 48'h0);
    rd_chk(cscr_pkg::OFF_LOW_POWER, 32'h0000_0000);
    // Sub-word writes land in their own lanes only
    bus(1'b1, cscr_pkg::OFF_FAULT_PRI + 32'h1, cscr_pkg::HSIZE_BYTE, 1'b1,
        32'h0000_AB00, d);
    bus(1'b1, cscr_pkg::OFF_TIMER_PRI + 32'h2, cscr_pkg::HSIZE_HALF, 1'b1,
        32'h5A7C_0000, d);
    rd_chk(cscr_pkg::OFF_FAULT_PRI, 32'h0000_A000);
    rd_chk(cscr_pkg::OFF_TIMER_PRI, 32'h5070_0000);
    check(prio, 48'h00A0_0000_7050);
    // Deep sleep on wait; disabled irq ignored; send-event wakes
    wr(cscr_pkg::OFF_LOW_POWER, 32'h0000_0004);
    pulse('{wait_for_event_instruction:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.deep_sleep}, 48'h3);
    pulse('{irq_pend_dis:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h2);
    pulse('{send_event_instruction:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h1);
    // Wake on any pending: disabled irq wakes, ordinary sleep
    wr(cscr_pkg::OFF_LOW_POWER, 32'h0000_0010);
    pulse('{wait_for_event_instruction:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.deep_sleep}, 48'h2);
    pulse('{irq_pend_dis:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h1);
    // Event latched while running satisfies the next wait
    pulse('{event_en:1'b1, default:1'b0});
    pulse('{wait_for_event_instruction:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h1);
    pulse('{wait_for_event_instruction:1'b1, default:1'b0});
    check({47'h0, core_out.sleeping}, 48'h1);
    // External event pin wakes through its synchroniser
    @(posedge hclk);
    ext_event <= 1'b1;
    @(posedge hclk);
    ext_event <= 1'b0;
    found = 1'b0;
    for (int n = 0; n < 8 && !found; n++) begin
      @(posedge hclk);
      #1;
      found = (core_out.wake === 1'b1);
    end
    check({47'h0, found}, 48'h1);
    // Wait and send-event on consecutive edges
    @(posedge hclk);
    core_in <= '{wait_for_event_instruction:1'b1, default:1'b0};
    @(posedge hclk);
    core_in <= '{send_event_instruction:1'b1, default:1'b0};
    @(posedge hclk);
    core_in <= '0;
    #1;
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h1);
    // Sleep on return to Thread only with the bit set
    wr(cscr_pkg::OFF_LOW_POWER, 32'h0000_0002);
    pulse('{handler_return:1'b1, default:1'b0});
    check({47'h0, core_out.sleeping}, 48'h1);
    pulse('{irq_pend_en:1'b1, default:1'b0});
    check({46'h0, core_out.sleeping, core_out.wake}, 48'h1);
    wr(cscr_pkg::OFF_LOW_POWER, 32'h0000_0000);
    pulse('{handler_return:1'b1, default:1'b0});
    check({47'h0, core_out.sleeping}, 48'h0);
    // Top-priority data fault without ignore locks the core up
    wr(cscr_pkg::OFF_CORE_CFG, 32'h0000_0000);
    pulse('{dbus_fault:1'b1, top_priority:1'b1, default:1'b0});
    repeat (4) @(posedge hclk);
    #1;
    check({47'h0, core_out.lockup}, 48'h1);
    finish_test();
  end
endmodule
`default_nettype wire
